// ---- include/tsu_consts.svh ----
// register indices, field positions, reset values and timing counts of the capture unit
`ifndef TSU_CONSTS_SVH
`define TSU_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TSU_IDX_STATUS     11'h420
`define TSU_IDX_CFG        11'h422
`define TSU_IDX_NS_LOW     11'h424
`define TSU_IDX_NS_HIGH    11'h426
`define TSU_IDX_SEC_LOW    11'h428
`define TSU_IDX_SEC_HIGH   11'h42a

// ----------------------------------------------------------------
// config fields and reset values
// ----------------------------------------------------------------
`define TSU_CFG_RESET      16'h0000
`define TSU_CFG_MASK       16'h0fff
`define TSU_PIN_MSB        11
`define TSU_PIN_LSB        8
`define TSU_RISE_BIT       7
`define TSU_FALL_BIT       6
`define TSU_TAIL_BIT       5
`define TSU_UP_MSB         4
`define TSU_UP_LSB         1
`define TSU_CASC_BIT       0
`define TSU_EDGE_BIT       14
`define TSU_CNT_LSB        1
`define TSU_OVFL_BIT       0
`define TSU_CAP_RESET      16'h0000

// ----------------------------------------------------------------
// counts and timing
// ----------------------------------------------------------------
`define TSU_CNT_MAX        4'hf
`define TSU_CASCADE_MAX    4'h2
`define TSU_NS_RES_NS      40
`define TSU_CLK_MHZ        50
`define TSU_EVENT_MHZ      25
`define TSU_EVENT_CYCLES   ((`TSU_CLK_MHZ + `TSU_EVENT_MHZ - 1) / `TSU_EVENT_MHZ)

`endif

// ---- include/tsu_pkg.sv ----
// types shared by the capture unit files
package tsu_pkg;

	typedef logic [15:0] tsu_word_type;

	typedef enum {
		TSU_REG_STATUS,
		TSU_REG_CFG,
		TSU_REG_NS_LOW,
		TSU_REG_NS_HIGH,
		TSU_REG_SEC_LOW,
		TSU_REG_SEC_HIGH,
		TSU_REG_NONE
	} tsu_reg_type;

endpackage : tsu_pkg

// ---- hdl/tsu_pin_edge.sv ----
// selected input pin and its rising and falling edge pulses
module tsu_pin_edge #(
	parameter int PIN_COUNT = 12,
	parameter int SEL_W     = 4
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset_n,
	// pins and selection
	input  wire logic [PIN_COUNT-1:0] pin_in,
	input  wire logic [SEL_W-1:0]     pin_sel,
	// edge pulses
	output logic                      rise_pulse,
	output logic                      fall_pulse
);

	logic [SEL_W-1:0] sel_q;
	logic [SEL_W-1:0] sel_prev;
	logic             pin_q;
	logic             pin_prev;
	logic             sel_steady;

	generate
		if (PIN_COUNT < 1 || PIN_COUNT > (1 << SEL_W)) begin : g_bad_pins
			$error("pin count does not fit the select width");
		end
	endgenerate

	assign sel_steady = (sel_q == sel_prev);

	// ----------------------------------------------------------------
	// pin selection and edge detection
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			sel_q      <= '0;
			sel_prev   <= '0;
			pin_q      <= 1'b0;
			pin_prev   <= 1'b0;
			rise_pulse <= 1'b0;
			fall_pulse <= 1'b0;
		end else begin
			sel_q    <= pin_sel;
			sel_prev <= sel_q;
			// unused codes select no pin
			pin_q    <= (32'(pin_sel) < PIN_COUNT) ? pin_in[pin_sel] : 1'b0;
			pin_prev <= pin_q;
			// a change of selection is not an edge
			rise_pulse <= sel_steady & pin_q & ~pin_prev;
			fall_pulse <= sel_steady & ~pin_q & pin_prev;
		end
	end

endmodule : tsu_pin_edge

// ---- hdl/tsu_capture_unit.sv ----
// timestamp input unit: config, first-event capture, event count, apb slave
//
// What this block does
// - four-bit field picks one of twelve input pins; codes 12 to 15 select none.
// - rising-edge enable makes low-to-high transitions capture events.
// - falling-edge enable makes high-to-low transitions capture events; both may be on.
// - tail bit marks the last unit of a cascade chain.
// - upstream code picks the unit whose done gates this one; head uses zero.
// - cascade-enable bit makes the unit a chained cascade member.
// - first event nanoseconds kept at the 40 ns timebase resolution.
// - polarity bit set for a rising first event, clear for falling.
// - 30-bit nanoseconds split: 15:0 low register, 29:16 in high register bits 13:0.
// - 32-bit seconds split over two read-only 16-bit registers.
// - counter saturates at 15; non-tail cascade members stop after two events.
// - edges at up to 25 MHz are each detected and counted.
`include "tsu_consts.svh"

module tsu_capture_unit #(
	parameter int PIN_COUNT  = 12,
	parameter int UNIT_COUNT = 12,
	parameter int NS_W       = 30,
	parameter int SEC_W      = 32,
	parameter int ADDR_W     = 13
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// event pins and local time
	input  wire logic [PIN_COUNT-1:0]  event_pin,
	input  wire logic [SEC_W-1:0]      time_sec,
	input  wire logic [NS_W-1:0]       time_ns,
	// unit enable and cascade chain
	input  wire logic                  unit_enable,
	input  wire logic [UNIT_COUNT-1:0] upstream_done,
	output logic                       unit_done
);

	generate
		if (NS_W != 30 || SEC_W != 32 || ADDR_W < 13 || UNIT_COUNT > 15) begin : g_bad_params
			$error("capture unit parameters out of range");
		end
		if (`TSU_EVENT_CYCLES < 1) begin : g_bad_rate
			$error("clock too slow for the event rate");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [15:0]      cfg;
	logic [3:0]       event_count;
	logic             count_ovfl;
	logic [NS_W-1:0]  first_ns;
	logic [SEC_W-1:0] first_sec;
	logic             first_rising;
	logic             rise_pulse;
	logic             fall_pulse;
	logic             armed;
	logic             edge_hit;
	logic             take_event;
	logic [3:0]       count_limit;
	logic [3:0]       up_sel;
	logic [3:0]       next_count;
	logic             wr_cfg;
	tsu_pkg::tsu_reg_type rd_sel;

	assign up_sel = cfg[`TSU_UP_MSB:`TSU_UP_LSB];

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic tsu_pkg::tsu_reg_type decode(input logic [ADDR_W-1:0] a);
		tsu_pkg::tsu_reg_type r;
		r = tsu_pkg::TSU_REG_NONE;
		if (a[1:0] == 2'h0 && (a >> 13) == '0) begin
			unique case (a[12:2])
				`TSU_IDX_STATUS:   r = tsu_pkg::TSU_REG_STATUS;
				`TSU_IDX_CFG:      r = tsu_pkg::TSU_REG_CFG;
				`TSU_IDX_NS_LOW:   r = tsu_pkg::TSU_REG_NS_LOW;
				`TSU_IDX_NS_HIGH:  r = tsu_pkg::TSU_REG_NS_HIGH;
				`TSU_IDX_SEC_LOW:  r = tsu_pkg::TSU_REG_SEC_LOW;
				`TSU_IDX_SEC_HIGH: r = tsu_pkg::TSU_REG_SEC_HIGH;
				default:           r = tsu_pkg::TSU_REG_NONE;
			endcase
		end
		return r;
	endfunction : decode

	// ----------------------------------------------------------------
	// pin edge detector
	// ----------------------------------------------------------------
	tsu_pin_edge #(
		.PIN_COUNT (PIN_COUNT),
		.SEL_W     (4)
	) u_pin_edge (
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.pin_in     (event_pin),
		.pin_sel    (cfg[`TSU_PIN_MSB:`TSU_PIN_LSB]),
		.rise_pulse (rise_pulse),
		.fall_pulse (fall_pulse)
	);

	// ----------------------------------------------------------------
	// event qualification
	// ----------------------------------------------------------------
	always_comb begin
		// head or single unit is always armed
		if (!cfg[`TSU_CASC_BIT] || up_sel == 4'h0) begin
			armed = 1'b1;
		end else if (32'(up_sel) <= UNIT_COUNT) begin
			armed = upstream_done[up_sel - 4'h1];
		end else begin
			armed = 1'b0;
		end
	end

	assign edge_hit = (rise_pulse & cfg[`TSU_RISE_BIT])
		| (fall_pulse & cfg[`TSU_FALL_BIT]);
	assign count_limit = (cfg[`TSU_CASC_BIT] && !cfg[`TSU_TAIL_BIT])
		? `TSU_CASCADE_MAX : `TSU_CNT_MAX;
	// non-tail cascade members stop once their share is taken
	assign take_event = unit_enable & armed & edge_hit
		& ~(count_limit == `TSU_CASCADE_MAX && event_count >= `TSU_CASCADE_MAX);
	assign next_count = (event_count == `TSU_CNT_MAX) ? event_count
		: event_count + 4'h1;

	// ----------------------------------------------------------------
	// event counter and overflow
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			event_count <= 4'h0;
			count_ovfl  <= 1'b0;
		end else if (take_event) begin
			event_count <= next_count;
			if (event_count == `TSU_CNT_MAX) begin
				count_ovfl <= 1'b1;
			end
		end else if (!unit_enable) begin
			event_count <= 4'h0;
			count_ovfl  <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// first-event capture
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			first_ns     <= '0;
			first_sec    <= '0;
			first_rising <= 1'b0;
		end else if (take_event && event_count == 4'h0) begin
			// timebase ticks in 40 ns steps
			first_ns     <= time_ns;
			first_sec    <= time_sec;
			first_rising <= rise_pulse & cfg[`TSU_RISE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// cascade done
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			unit_done <= 1'b0;
		end else begin
			unit_done <= cfg[`TSU_CASC_BIT] && unit_enable
				&& (take_event ? next_count : event_count) >= count_limit;
		end
	end

	// ----------------------------------------------------------------
	// config register
	// ----------------------------------------------------------------
	assign wr_cfg = psel & penable & pready & pwrite
		& (decode(paddr) == tsu_pkg::TSU_REG_CFG);

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cfg <= `TSU_CFG_RESET;
		end else if (wr_cfg) begin
			cfg <= pwdata[15:0] & `TSU_CFG_MASK;
		end
	end

	// ----------------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------------
	assign rd_sel = decode(paddr);

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && !penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= (rd_sel == tsu_pkg::TSU_REG_NONE);
			prdata  <= 32'h0000_0000;
			if (!pwrite) begin
				unique case (rd_sel)
					tsu_pkg::TSU_REG_STATUS:   prdata[4:0]  <= {event_count, count_ovfl};
					tsu_pkg::TSU_REG_CFG:      prdata[15:0] <= cfg;
					tsu_pkg::TSU_REG_NS_LOW:   prdata[15:0] <= first_ns[15:0];
					tsu_pkg::TSU_REG_NS_HIGH:  prdata[14:0] <= {first_rising,
						first_ns[29:16]};
					tsu_pkg::TSU_REG_SEC_LOW:  prdata[15:0] <= first_sec[15:0];
					tsu_pkg::TSU_REG_SEC_HIGH: prdata[15:0] <= first_sec[31:16];
					tsu_pkg::TSU_REG_NONE:     prdata       <= 32'h0000_0000;
				endcase
			end
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_setup;
		psel && !penable && !pready;
	endsequence

	sequence s_first_take;
		take_event && event_count == 4'h0;
	endsequence

	a_cfg_write_mask: assert property (
		wr_cfg |=> cfg == ($past(pwdata[15:0]) & `TSU_CFG_MASK))
		else $error("config write not stored with reserved bits cleared");

	a_unused_pin_quiet: assert property (
		(cfg[11:10] == 2'h3) [*3] |-> !rise_pulse && !fall_pulse)
		else $error("edge reported on an unused pin code");

	a_rise_gate: assert property (
		rise_pulse && !cfg[`TSU_RISE_BIT] && !fall_pulse |-> !take_event)
		else $error("rising edge taken while disabled");

	a_fall_gate: assert property (
		fall_pulse && !cfg[`TSU_FALL_BIT] && !rise_pulse |-> !take_event)
		else $error("falling edge taken while disabled");

	a_first_polarity: assert property (
		s_first_take |=> first_rising == $past(rise_pulse && cfg[`TSU_RISE_BIT]))
		else $error("first event polarity wrong");

	a_first_time: assert property (
		s_first_take |=> first_sec == $past(time_sec) && first_ns == $past(time_ns))
		else $error("first event time not captured");

	a_first_held: assert property (
		event_count != 4'h0 && unit_enable |=> $stable(first_ns) && $stable(first_sec))
		else $error("first sample overwritten by a later event");

	a_count_step: assert property (
		take_event && event_count < count_limit |=> event_count == $past(event_count) + 4'h1)
		else $error("event not counted");

	a_count_saturate: assert property (
		event_count == `TSU_CNT_MAX && unit_enable |=> event_count == `TSU_CNT_MAX)
		else $error("counter left saturation");

	a_nontail_limit: assert property (
		cfg[`TSU_CASC_BIT] && !cfg[`TSU_TAIL_BIT] && event_count <= `TSU_CASCADE_MAX
		|=> event_count <= `TSU_CASCADE_MAX)
		else $error("non-tail member took more than two events");

	a_done_nontail: assert property (
		(cfg[`TSU_CASC_BIT] && !cfg[`TSU_TAIL_BIT] && unit_enable
		&& event_count == `TSU_CASCADE_MAX) [*2] |-> unit_done)
		else $error("non-tail member not done after two events");

	a_upstream_gate: assert property (
		cfg[`TSU_CASC_BIT] && up_sel != 4'h0 && up_sel <= 4'hc
		&& !upstream_done[up_sel - 4'h1] |-> !take_event)
		else $error("event taken before upstream done");

	a_no_cascade: assert property (
		!cfg[`TSU_CASC_BIT] |=> !unit_done)
		else $error("done raised outside cascade mode");

	a_ns_high_read: assert property (
		s_setup ##0 (!pwrite && rd_sel == tsu_pkg::TSU_REG_NS_HIGH)
		|=> pready && prdata[31:15] == 17'h0_0000 && prdata[13:0] == $past(first_ns[29:16]))
		else $error("nanoseconds high word misplaced");

	a_sec_high_read: assert property (
		s_setup ##0 (!pwrite && rd_sel == tsu_pkg::TSU_REG_SEC_HIGH)
		|=> pready && prdata == {16'h0000, $past(first_sec[31:16])})
		else $error("seconds high word misplaced");

	a_apb_answer: assert property (
		s_setup |=> pready ##1 !pready)
		else $error("apb answer not one cycle wide");

endmodule : tsu_capture_unit

// ---- dv/tsu_event_src.sv ----
// event source model driving the selectable input pins
module tsu_event_src (
	// clock
	input  wire logic        core_clk,
	// event pins
	output logic      [11:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;

	initial pin = 12'h000;

	// ----------------------------------------------------------------
	// toggle one pin after an edge, then hold it
	// ----------------------------------------------------------------
	task automatic toggle(input int p, input int hold);
		@(posedge core_clk);
		pin[p] <= ~pin[p];
		repeat (hold) @(posedge core_clk);
	endtask : toggle

endmodule : tsu_event_src

// ---- dv/ptp_timestamp_input_unit_tb.sv ----
// self-checking bench of the capture unit with a register model
module ptp_timestamp_input_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic        unit_enable, unit_done;
	logic [12:0] paddr;
	logic [31:0] pwdata, prdata, time_sec, d;
	logic [29:0] time_ns;
	logic [11:0] upstream_done, event_pin;
	logic [15:0] cfg;
	logic [3:0]  m_cnt;
	logic        m_ovfl, m_edge, m_has, e;
	logic [31:0] m_sec;
	logic [29:0] m_ns;
	int          err_total, samples_checked, cycles, p, m;

	tsu_capture_unit u_tsu_capture_unit (
		.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .event_pin(event_pin),
		.time_sec(time_sec), .time_ns(time_ns), .unit_enable(unit_enable),
		.upstream_done(upstream_done), .unit_done(unit_done)
	);
	tsu_event_src u_tsu_event_src (.core_clk(core_clk), .pin(event_pin));

	// ----------------------------------------------------------------
	// compare, bus and model tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		samples_checked++;
		if (g !== ex) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, ex, g);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next request never reassigns psel in this step
		@(posedge core_clk);
	endtask : apb

	task automatic rchk(input string nm, input logic [12:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, ex, d);
		chk("pslverr", 32'h0000_0000, {31'h0, e});
	endtask : rchk

	task automatic wcfg(input logic [31:0] v);
		apb(1'b1, 13'h1088, v);
		cfg = v[15:0] & 16'h0fff;
		repeat (4) @(posedge core_clk);
	endtask : wcfg

	task automatic ev(input int q, input int hold);
		logic rise, armed;
		int up;
		u_tsu_event_src.toggle(q, hold);
		rise = u_tsu_event_src.pin[q];
		up = cfg[4:1];
		armed = (up == 0) ? 1'b1 : (up <= 12) ? upstream_done[(up+11)%12] : 1'b0;
		if (!unit_enable || cfg[11:8] != q || !(rise ? cfg[7] : cfg[6])) return;
		if (cfg[0] && (!armed || (!cfg[5] && m_cnt >= 2))) return;
		if (!m_has) begin
			m_has = 1'b1;
			m_ns = time_ns;
			m_sec = time_sec;
			m_edge = rise;
		end
		if (m_cnt == 4'hf) m_ovfl = 1'b1;
		else m_cnt++;
	endtask : ev

	task automatic check_all();
		repeat (4) @(posedge core_clk);
		rchk("config", 13'h1088, {16'h0000, cfg});
		rchk("status", 13'h1080, {27'h0, m_cnt, m_ovfl});
		rchk("ns_low", 13'h1090, {16'h0000, m_ns[15:0]});
		rchk("ns_high_edge", 13'h1098, {17'h0, m_edge, m_ns[29:16]});
		rchk("sec_low", 13'h10a0, {16'h0000, m_sec[15:0]});
		rchk("sec_high", 13'h10a8, {16'h0000, m_sec[31:16]});
		chk("unit_done", {31'h0, cfg[0] && m_cnt == (cfg[5] ? 4'hf : 4'h2)}, unit_done);
	endtask : check_all

	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		{cfg, m_cnt, m_ovfl, m_edge, m_has, m_sec, m_ns} = '0;
		@(posedge core_clk);
	endtask : do_reset

	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	// ----------------------------------------------------------------
	// clock, timeout and scenarios
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, time_sec, time_ns} = '0;
		unit_enable = 1'b1;
		upstream_done = 12'h000;
		void'($urandom(60));
		do_reset();
		check_all();
		apb(1'b0, 13'h10b0, 32'h0000_0000);
		chk("unmapped_err", 32'h0000_0001, {31'h0, e});
		wcfg($urandom);
		check_all();
		for (m = 1; m < 4; m++) begin
			do_reset();
			p = $urandom_range(11);
			time_sec <= $urandom;
			time_ns <= 30'($urandom_range(24999999) * 40);
			wcfg({20'h0, p[3:0], m[0], m[1], 6'h00});
			ev(p, 4);
			time_sec <= ~time_sec;
			ev(p, 4);
			ev(p, 4);
			ev((p + 1) % 12, 4);
			check_all();
		end
		for (m = 0; m < 2; m++) begin
			do_reset();
			p = $urandom_range(11);
			wcfg({20'h0, p[3:0], 2'b11, m[0], 4'h0, m[0]});
			repeat (17) ev(p, 1);
			check_all();
		end
		do_reset();
		wcfg(32'h0000_0cc0);
		ev(11, 2);
		ev(0, 2);
		check_all();
		upstream_done <= 12'($urandom) & 12'hffb;
		wcfg({20'h0, 4'h5, 2'b11, 1'b0, 4'h3, 1'b1});
		repeat (2) ev(5, 2);
		check_all();
		upstream_done[2] <= 1'b1;
		repeat (2) @(posedge core_clk);
		repeat (4) ev(5, 2);
		check_all();
		unit_enable <= 1'b0;
		{m_cnt, m_ovfl} = '0;
		ev(5, 2);
		check_all();
		conclude();
	end

endmodule : ptp_timestamp_input_unit_tb
